// ### verilog/gpeh_pkg.sv
/*
 * Shared constants for the port E to H general-purpose I/O block: port widths, positions of each
 * port inside the flat pin vector, peripheral pin positions, register indices and byte addresses.
 * Assumes a 32-bit APB slave in which each register takes one aligned word.
 */
package gpeh_pkg;
   localparam int unsigned PORT_E_W = 8;
   localparam int unsigned PORT_F_W = 7;
   localparam int unsigned PORT_G_W = 3;
   localparam int unsigned PORT_H_W = 2;
   localparam int unsigned PIN_W = PORT_E_W + PORT_F_W + PORT_G_W + PORT_H_W;
   localparam int unsigned TIMER_A_W = 4;
   localparam int unsigned TIMER_B_W = 2;
   localparam int unsigned KEYPAD_W = 5;
   localparam int unsigned ADDR_W = 12;

   // Base of each port inside the flat pin vector.
   localparam int unsigned BASE_E = 0;
   localparam int unsigned BASE_F = BASE_E + PORT_E_W;
   localparam int unsigned BASE_G = BASE_F + PORT_F_W;
   localparam int unsigned BASE_H = BASE_G + PORT_G_W;

   // Peripheral pin positions inside their own ports; the keypad offsets are positions in the keypad enable vector.
   localparam int unsigned E_TX_BIT = 0;
   localparam int unsigned E_RX_BIT = 1;
   localparam int unsigned F_TIMER_A_LSB = 0;
   localparam int unsigned F_TIMER_B_LSB = 4;
   localparam int unsigned KEYPAD_G_LSB = 0;
   localparam int unsigned KEYPAD_H_LSB = 3;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_PORT_E_LATCH = 8'h08;
   localparam logic [7:0] IDX_PORT_F_LATCH = 8'h09;
   localparam logic [7:0] IDX_PORT_G_LATCH = 8'h0a;
   localparam logic [7:0] IDX_PORT_H_LATCH = 8'h0b;
   localparam logic [7:0] IDX_PORT_E_DIRECTION = 8'h0c;
   localparam logic [7:0] IDX_PORT_F_DIRECTION = 8'h0d;
   localparam logic [7:0] IDX_PORT_G_DIRECTION = 8'h0e;
   localparam logic [7:0] IDX_PORT_H_DIRECTION = 8'h0f;
   localparam logic [ADDR_W-1:0] ADDR_PORT_E_LATCH = {2'h0, IDX_PORT_E_LATCH, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_PORT_F_LATCH = {2'h0, IDX_PORT_F_LATCH, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_PORT_G_LATCH = {2'h0, IDX_PORT_G_LATCH, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_PORT_H_LATCH = {2'h0, IDX_PORT_H_LATCH, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_PORT_E_DIRECTION = {2'h0, IDX_PORT_E_DIRECTION, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_PORT_F_DIRECTION = {2'h0, IDX_PORT_F_DIRECTION, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_PORT_G_DIRECTION = {2'h0, IDX_PORT_G_DIRECTION, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_PORT_H_DIRECTION = {2'h0, IDX_PORT_H_DIRECTION, 2'h0};

   // Reset values.
   localparam logic [PIN_W-1:0] DIRECTION_RESET = 20'h00000;
   localparam logic [PIN_W-1:0] PIN_RESET = 20'h00000;
endpackage

// ### verilog/gpeh_ports.sv
/*
 * General-purpose I/O for ports E, F, G and H with an APB register slave, pin ownership by the
 * serial interface, timers A and B and the keypad interrupt logic, and three-stage pin sampling.
 * Assumes a 40 MHz i_clock, peripherals on the same clock, and pad logic that resolves each pin
 * from its output and output enable.
 */
// Our own choice: register access over APB.
// Overview of operation
// - Serial enable makes E1 the receive input and E0 the transmit output.
// - Serial-owned port E pins ignore direction for drive; direction still selects read source.
// - Direction bit one enables the pin driver; zero leaves the pin undriven input.
// - Reset clears all direction bits of ports E, F, G and H.
// - Port E data read gives latch where direction is one, pin otherwise.
// - Port F data read gives latch where direction is one, pin otherwise.
// - Port G data read gives latch where direction is one, pin otherwise.
// - Port H data read gives latch where direction is one, pin otherwise.
// - Data writes always update the latch; input pins read unchanged.
// - Reset leaves the port F, G and H latches untouched.
// - Ports F, G, H are 7, 3 and 2 bits, each bit latched.
// - Port F bits 3..0 serve timer A channels when selected, else GPIO.
// - Port F bits 5..4 serve timer B channels 1..0 when selected.
// - Timer-owned port F pins ignore direction for drive; direction still selects read.
// - Keypad enable on a port G pin makes it an input, overriding direction.
// - Keypad enable bits 4..3 turn port H pins into interrupt inputs.
`timescale 1ns/1ps
module gpeh_ports (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [gpeh_pkg::ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [gpeh_pkg::PORT_E_W-1:0] i_port_e_pin,
   input wire logic [gpeh_pkg::PORT_F_W-1:0] i_port_f_pin,
   input wire logic [gpeh_pkg::PORT_G_W-1:0] i_port_g_pin,
   input wire logic [gpeh_pkg::PORT_H_W-1:0] i_port_h_pin,
   output logic [gpeh_pkg::PORT_E_W-1:0] o_port_e_out,
   output logic [gpeh_pkg::PORT_F_W-1:0] o_port_f_out,
   output logic [gpeh_pkg::PORT_G_W-1:0] o_port_g_out,
   output logic [gpeh_pkg::PORT_H_W-1:0] o_port_h_out,
   output logic [gpeh_pkg::PORT_E_W-1:0] o_port_e_oe,
   output logic [gpeh_pkg::PORT_F_W-1:0] o_port_f_oe,
   output logic [gpeh_pkg::PORT_G_W-1:0] o_port_g_oe,
   output logic [gpeh_pkg::PORT_H_W-1:0] o_port_h_oe,
   input wire logic i_serial_iface_enable,
   input wire logic i_serial_tx_data,
   output logic o_serial_rx_data,
   input wire logic [gpeh_pkg::TIMER_A_W-1:0] i_timer_a_edge_level_select,
   input wire logic [gpeh_pkg::TIMER_A_W-1:0] i_timer_a_oe,
   input wire logic [gpeh_pkg::TIMER_A_W-1:0] i_timer_a_out,
   output logic [gpeh_pkg::TIMER_A_W-1:0] o_timer_a_channel_pin,
   input wire logic [gpeh_pkg::TIMER_B_W-1:0] i_timer_b_edge_level_select,
   input wire logic [gpeh_pkg::TIMER_B_W-1:0] i_timer_b_oe,
   input wire logic [gpeh_pkg::TIMER_B_W-1:0] i_timer_b_out,
   output logic [gpeh_pkg::TIMER_B_W-1:0] o_timer_b_channel_pin,
   input wire logic [gpeh_pkg::KEYPAD_W-1:0] i_keypad_irq_enable,
   output logic [gpeh_pkg::KEYPAD_W-1:0] o_keypad_wake_pins
);
   import gpeh_pkg::*;

   logic [PIN_W-1:0] direction;
   logic [PIN_W-1:0] latch;
   logic [PIN_W-1:0] sync_a;
   logic [PIN_W-1:0] sync_b;
   logic [PIN_W-1:0] sync_c;
   logic [PIN_W-1:0] level;
   logic [PIN_W-1:0] pin_oe;
   logic [PIN_W-1:0] pin_out;
   logic [PIN_W-1:0] next_pin_oe;
   logic [PIN_W-1:0] next_pin_out;
   logic [31:0] next_prdata;

   wire [PIN_W-1:0] pins_in = {i_port_h_pin, i_port_g_pin, i_port_f_pin, i_port_e_pin};

   // APB decode. The answer is registered, so every access phase lasts exactly one cycle.
   wire setup = i_psel & ~i_penable;
   wire access_done = i_psel & i_penable & o_pready;
   wire sel_e_latch = (i_paddr == ADDR_PORT_E_LATCH);
   wire sel_f_latch = (i_paddr == ADDR_PORT_F_LATCH);
   wire sel_g_latch = (i_paddr == ADDR_PORT_G_LATCH);
   wire sel_h_latch = (i_paddr == ADDR_PORT_H_LATCH);
   wire sel_e_dir = (i_paddr == ADDR_PORT_E_DIRECTION);
   wire sel_f_dir = (i_paddr == ADDR_PORT_F_DIRECTION);
   wire sel_g_dir = (i_paddr == ADDR_PORT_G_DIRECTION);
   wire sel_h_dir = (i_paddr == ADDR_PORT_H_DIRECTION);
   wire mapped = sel_e_latch | sel_f_latch | sel_g_latch | sel_h_latch |
                 sel_e_dir | sel_f_dir | sel_g_dir | sel_h_dir;
   wire write_done = access_done & i_pwrite;

   // Write masks over the flat vector; each register reaches only its own port's bits.
   wire [PIN_W-1:0] mask_e = {{(PIN_W-PORT_E_W){1'b0}}, {PORT_E_W{1'b1}}};
   wire [PIN_W-1:0] mask_f = {{(PIN_W-BASE_G){1'b0}}, {PORT_F_W{1'b1}}, {BASE_F{1'b0}}};
   wire [PIN_W-1:0] mask_g = {{PORT_H_W{1'b0}}, {PORT_G_W{1'b1}}, {BASE_G{1'b0}}};
   wire [PIN_W-1:0] mask_h = {{PORT_H_W{1'b1}}, {BASE_H{1'b0}}};
   wire [PIN_W-1:0] wdata_flat = {i_pwdata[PORT_H_W-1:0], i_pwdata[PORT_G_W-1:0],
                                  i_pwdata[PORT_F_W-1:0], i_pwdata[PORT_E_W-1:0]};
   wire [PIN_W-1:0] latch_wmask = {PIN_W{write_done}} &
      (({PIN_W{sel_e_latch}} & mask_e) | ({PIN_W{sel_f_latch}} & mask_f) |
       ({PIN_W{sel_g_latch}} & mask_g) | ({PIN_W{sel_h_latch}} & mask_h));
   wire [PIN_W-1:0] dir_wmask = {PIN_W{write_done}} &
      (({PIN_W{sel_e_dir}} & mask_e) | ({PIN_W{sel_f_dir}} & mask_f) |
       ({PIN_W{sel_g_dir}} & mask_g) | ({PIN_W{sel_h_dir}} & mask_h));

   // A pin reads its latch when its direction bit is set, its sampled level otherwise.
   wire [PIN_W-1:0] read_view = (direction & latch) | (~direction & level);
   wire [PORT_E_W-1:0] read_e = read_view[BASE_E +: PORT_E_W];
   wire [PORT_F_W-1:0] read_f = read_view[BASE_F +: PORT_F_W];
   wire [PORT_G_W-1:0] read_g = read_view[BASE_G +: PORT_G_W];
   wire [PORT_H_W-1:0] read_h = read_view[BASE_H +: PORT_H_W];

   always_comb begin
      next_prdata = 32'h00000000;
      if (setup && !i_pwrite) begin
         if (sel_e_latch) begin
            next_prdata = {24'h000000, read_e};
         end else if (sel_f_latch) begin
            next_prdata = {25'h0000000, read_f};
         end else if (sel_g_latch) begin
            next_prdata = {29'h00000000, read_g};
         end else if (sel_h_latch) begin
            next_prdata = {30'h00000000, read_h};
         end else if (sel_e_dir) begin
            next_prdata = {24'h000000, direction[BASE_E +: PORT_E_W]};
         end else if (sel_f_dir) begin
            next_prdata = {25'h0000000, direction[BASE_F +: PORT_F_W]};
         end else if (sel_g_dir) begin
            next_prdata = {29'h00000000, direction[BASE_G +: PORT_G_W]};
         end else if (sel_h_dir) begin
            next_prdata = {30'h00000000, direction[BASE_H +: PORT_H_W]};
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
      end else begin
         o_pready <= setup;
         o_pslverr <= setup & ~mapped;
         o_prdata <= next_prdata;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         direction <= DIRECTION_RESET;
      end else begin
         direction <= (direction & ~dir_wmask) | (wdata_flat & dir_wmask);
      end
   end

   // The latches carry no reset, so their contents survive a system reset.
   always_ff @(posedge i_clock) begin
      latch <= (latch & ~latch_wmask) | (wdata_flat & latch_wmask);
   end

   // Three-stage sampling; a level change counts once the second and third stages agree.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         sync_a <= PIN_RESET;
         sync_b <= PIN_RESET;
         sync_c <= PIN_RESET;
         level <= PIN_RESET;
      end else begin
         sync_a <= pins_in;
         sync_b <= sync_a;
         sync_c <= sync_b;
         level <= (sync_b & ~(sync_b ^ sync_c)) | (level & (sync_b ^ sync_c));
      end
   end

   // Pin ownership by the on-chip peripherals.
   wire [PIN_W-1:0] own_en = {i_keypad_irq_enable[KEYPAD_H_LSB +: PORT_H_W],
                              i_keypad_irq_enable[KEYPAD_G_LSB +: PORT_G_W],
                              1'b0, i_timer_b_edge_level_select,
                              i_timer_a_edge_level_select,
                              6'h00, i_serial_iface_enable, i_serial_iface_enable};
   wire [PIN_W-1:0] own_oe = {5'h00, 1'b0, i_timer_b_oe, i_timer_a_oe, 6'h00, 1'b0, 1'b1};
   wire [PIN_W-1:0] own_out = {5'h00, 1'b0, i_timer_b_out, i_timer_a_out, 6'h00, 1'b0, i_serial_tx_data};

   generate
      for (genvar i = 0; i < PIN_W; i++) begin : g_pin
         // An owned pin takes drive from its peripheral; otherwise the direction bit decides.
         assign next_pin_oe[i] = own_en[i] ? own_oe[i] : direction[i];
         // Data is forced low while undriven so that the pad never sees an unwritten latch.
         assign next_pin_out[i] = own_en[i] ? (own_oe[i] & own_out[i]) : (direction[i] & latch[i]);
      end
   endgenerate

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         pin_oe <= PIN_RESET;
         pin_out <= PIN_RESET;
      end else begin
         pin_oe <= next_pin_oe;
         pin_out <= next_pin_out;
      end
   end

   assign o_port_e_oe = pin_oe[BASE_E +: PORT_E_W];
   assign o_port_f_oe = pin_oe[BASE_F +: PORT_F_W];
   assign o_port_g_oe = pin_oe[BASE_G +: PORT_G_W];
   assign o_port_h_oe = pin_oe[BASE_H +: PORT_H_W];
   assign o_port_e_out = pin_out[BASE_E +: PORT_E_W];
   assign o_port_f_out = pin_out[BASE_F +: PORT_F_W];
   assign o_port_g_out = pin_out[BASE_G +: PORT_G_W];
   assign o_port_h_out = pin_out[BASE_H +: PORT_H_W];
   // Peripheral inputs see the filtered level whatever the direction bit holds.
   assign o_serial_rx_data = level[BASE_E + E_RX_BIT];
   assign o_timer_a_channel_pin = level[BASE_F + F_TIMER_A_LSB +: TIMER_A_W];
   assign o_timer_b_channel_pin = level[BASE_F + F_TIMER_B_LSB +: TIMER_B_W];
   assign o_keypad_wake_pins = {level[BASE_H +: PORT_H_W], level[BASE_G +: PORT_G_W]};

   AST_SERIAL_TX_DRIVES: assert property (@(posedge i_clock) disable iff (i_rst)
      (!$past(i_rst) && $past(i_serial_iface_enable)) |-> o_port_e_oe[E_TX_BIT] && !o_port_e_oe[E_RX_BIT] &&
      (o_port_e_out[E_TX_BIT] == $past(i_serial_tx_data)))
      else $error("serial pins not owned by the serial interface");

   AST_SERIAL_READ_DIR: assert property (@(posedge i_clock) disable iff (i_rst)
      (setup && !i_pwrite && sel_e_latch && i_serial_iface_enable && direction[E_RX_BIT])
      |=> o_prdata[E_RX_BIT] == $past(latch[E_RX_BIT]))
      else $error("port E read ignores direction while serial is on");

   AST_GPIO_DRIVE: assert property (@(posedge i_clock) disable iff (i_rst)
      (!$past(i_rst) && ($past(own_en) == 20'h00000)) |-> (pin_oe == $past(direction)) &&
      (pin_out == ($past(direction) & $past(latch))))
      else $error("free pin drive does not follow direction");

   AST_DIR_RESET: assert property (@(posedge i_clock)
      $fell(i_rst) |-> (direction == 20'h00000) && (pin_oe == 20'h00000))
      else $error("direction not cleared by reset");

   AST_READ_E: assert property (@(posedge i_clock) disable iff (i_rst)
      (access_done && !i_pwrite && sel_e_latch) |->
      o_prdata == {24'h000000, ($past(direction[7:0]) & $past(latch[7:0])) |
                   (~$past(direction[7:0]) & $past(level[7:0]))})
      else $error("port E read value wrong");

   AST_READ_F: assert property (@(posedge i_clock) disable iff (i_rst)
      (access_done && !i_pwrite && sel_f_latch) |->
      o_prdata == {25'h0000000, ($past(direction[14:8]) & $past(latch[14:8])) |
                   (~$past(direction[14:8]) & $past(level[14:8]))})
      else $error("port F read value wrong");

   AST_READ_GH: assert property (@(posedge i_clock) disable iff (i_rst)
      (access_done && !i_pwrite && (sel_g_latch || sel_h_latch)) |->
      o_prdata == (sel_g_latch ? {29'h00000000, $past(read_g)} : {30'h00000000, $past(read_h)}))
      else $error("port G or H read value wrong");

   AST_LATCH_WRITE: assert property (@(posedge i_clock) disable iff (i_rst)
      (write_done && sel_f_latch) |=> (latch[14:8] == $past(i_pwdata[6:0])) && $stable(level[14:8]) &&
      ((pin_oe[14:8] & ~$past(direction[14:8]) & ~$past(own_en[14:8])) == 7'h00))
      else $error("port F latch write lost");

   AST_TIMER_OWN: assert property (@(posedge i_clock) disable iff (i_rst)
      (!$past(i_rst) && $past(i_timer_a_edge_level_select[0]) && $past(i_timer_b_edge_level_select[1])) |->
      (o_port_f_oe[0] == $past(i_timer_a_oe[0])) && (o_port_f_oe[5] == $past(i_timer_b_oe[1])))
      else $error("timer pin drive not owned by timer");

   AST_KEYPAD_INPUT: assert property (@(posedge i_clock) disable iff (i_rst)
      $past(i_keypad_irq_enable) == 5'h1f |-> (o_port_g_oe == 3'h0) && (o_port_h_oe == 2'h0))
      else $error("keypad pin still driven");

   AST_PREADY_ONE: assert property (@(posedge i_clock) disable iff (i_rst)
      setup |=> o_pready ##1 !o_pready)
      else $error("pready not a single cycle");

   // Pad drive is registered once, so drive checks look one cycle back and skip the reset release.
   AST_SERIAL_OFF_GPIO: assert property (@(posedge i_clock) disable iff (i_rst)
      (!$past(i_rst) && !$past(i_serial_iface_enable)) |-> (o_port_e_oe[1:0] == $past(direction[1:0])))
      else $error("serial pins not released to port E");

   AST_E_UPPER_GPIO: assert property (@(posedge i_clock) disable iff (i_rst)
      !$past(i_rst) |-> (o_port_e_oe[7:2] == $past(direction[7:2])) &&
      (o_port_e_out[7:2] == ($past(direction[7:2]) & $past(latch[7:2]))))
      else $error("port E upper drive wrong");

   AST_F6_GPIO: assert property (@(posedge i_clock) disable iff (i_rst)
      !$past(i_rst) |-> (o_port_f_oe[6] == $past(direction[BASE_F + 6])))
      else $error("port F bit 6 drive wrong");

   AST_TIMER_A_DRIVE: assert property (@(posedge i_clock) disable iff (i_rst)
      !$past(i_rst) |-> (o_port_f_oe[3:0] == (($past(i_timer_a_edge_level_select) & $past(i_timer_a_oe)) |
      (~$past(i_timer_a_edge_level_select) & $past(direction[BASE_F +: TIMER_A_W])))))
      else $error("timer A drive enable wrong");

   AST_TIMER_A_OUT: assert property (@(posedge i_clock) disable iff (i_rst)
      !$past(i_rst) |-> (((o_port_f_out[3:0] ^ ($past(i_timer_a_oe) & $past(i_timer_a_out))) &
      $past(i_timer_a_edge_level_select)) == 4'h0))
      else $error("timer A pin value wrong");

   AST_TIMER_B_DRIVE: assert property (@(posedge i_clock) disable iff (i_rst)
      !$past(i_rst) |-> (o_port_f_oe[5:4] == (($past(i_timer_b_edge_level_select) & $past(i_timer_b_oe)) |
      (~$past(i_timer_b_edge_level_select) & $past(direction[BASE_F + F_TIMER_B_LSB +: TIMER_B_W])))))
      else $error("timer B drive enable wrong");

   AST_TIMER_B_OUT: assert property (@(posedge i_clock) disable iff (i_rst)
      !$past(i_rst) |-> (((o_port_f_out[5:4] ^ ($past(i_timer_b_oe) & $past(i_timer_b_out))) &
      $past(i_timer_b_edge_level_select)) == 2'h0))
      else $error("timer B pin value wrong");

   AST_TIMER_READ_DIR: assert property (@(posedge i_clock) disable iff (i_rst)
      (setup && !i_pwrite && sel_f_latch && i_timer_a_edge_level_select[0] && direction[BASE_F])
      |=> o_prdata[0] == $past(latch[BASE_F]))
      else $error("port F read ignores direction while timer owns");

   AST_KEYPAD_G_BIT: assert property (@(posedge i_clock) disable iff (i_rst)
      !$past(i_rst) |-> (o_port_g_oe == (~$past(i_keypad_irq_enable[2:0]) & $past(direction[BASE_G +: PORT_G_W]))))
      else $error("port G keypad override wrong");

   AST_KEYPAD_H_BIT: assert property (@(posedge i_clock) disable iff (i_rst)
      !$past(i_rst) |-> (o_port_h_oe == (~$past(i_keypad_irq_enable[4:3]) & $past(direction[BASE_H +: PORT_H_W]))))
      else $error("port H keypad override wrong");

   AST_DIR_WRITE_E: assert property (@(posedge i_clock) disable iff (i_rst)
      (write_done && sel_e_dir) |=> (direction[BASE_E +: PORT_E_W] == $past(i_pwdata[PORT_E_W-1:0])))
      else $error("port E direction write lost");

   AST_DIR_WRITE_F: assert property (@(posedge i_clock) disable iff (i_rst)
      (write_done && sel_f_dir) |=> (direction[BASE_F +: PORT_F_W] == $past(i_pwdata[PORT_F_W-1:0])))
      else $error("port F direction write lost");

   AST_DIR_WRITE_G: assert property (@(posedge i_clock) disable iff (i_rst)
      (write_done && sel_g_dir) |=> (direction[BASE_G +: PORT_G_W] == $past(i_pwdata[PORT_G_W-1:0])))
      else $error("port G direction write lost");

   AST_DIR_WRITE_H: assert property (@(posedge i_clock) disable iff (i_rst)
      (write_done && sel_h_dir) |=> (direction[BASE_H +: PORT_H_W] == $past(i_pwdata[PORT_H_W-1:0])))
      else $error("port H direction write lost");

   AST_LATCH_WRITE_E: assert property (@(posedge i_clock) disable iff (i_rst)
      (write_done && sel_e_latch) |=> (latch[BASE_E +: PORT_E_W] == $past(i_pwdata[PORT_E_W-1:0])))
      else $error("port E latch write lost");

   AST_LATCH_WRITE_G: assert property (@(posedge i_clock) disable iff (i_rst)
      (write_done && sel_g_latch) |=> (latch[BASE_G +: PORT_G_W] == $past(i_pwdata[PORT_G_W-1:0])))
      else $error("port G latch write lost");

   AST_LATCH_WRITE_H: assert property (@(posedge i_clock) disable iff (i_rst)
      (write_done && sel_h_latch) |=> (latch[BASE_H +: PORT_H_W] == $past(i_pwdata[PORT_H_W-1:0])))
      else $error("port H latch write lost");

   AST_UNMAPPED_IGNORED: assert property (@(posedge i_clock) disable iff (i_rst)
      (write_done && !mapped) |=> $stable(direction) && $stable(latch))
      else $error("unmapped write changed a register");

   AST_PSLVERR_MAP: assert property (@(posedge i_clock) disable iff (i_rst)
      setup |=> (o_pslverr == !$past(mapped)))
      else $error("pslverr does not match the address map");

   AST_PREADY_CAUSE: assert property (@(posedge i_clock) disable iff (i_rst)
      o_pready |-> $past(setup))
      else $error("pready without a setup cycle");

   AST_PRDATA_IDLE: assert property (@(posedge i_clock) disable iff (i_rst)
      !o_pready |-> (o_prdata == 32'h00000000))
      else $error("read data not zero outside the access cycle");

   AST_LEVEL_TAKE: assert property (@(posedge i_clock) disable iff (i_rst)
      !$past(i_rst) |-> (((level ^ $past(sync_b)) & ~$past(sync_b ^ sync_c)) == 20'h00000))
      else $error("agreeing pin samples not taken");

   AST_LEVEL_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
      !$past(i_rst) |-> (((level ^ $past(level)) & $past(sync_b ^ sync_c)) == 20'h00000))
      else $error("pin level moved on disagreeing samples");
endmodule

// ### verification/gpeh_pad_model.sv
/*
 * Pad and far-side model for the port E to H block: resolves each pin from the block's drive.
 * Assumes flat 20-bit vectors ordered E, F, G, H from bit 0 and an external level per pin.
 */
`timescale 1ns/1ps
module gpeh_pad_model (
   input wire logic [19:0] i_oe,
   input wire logic [19:0] i_out,
   input wire logic [19:0] i_ext,
   output logic [19:0] o_pin
);
   // An undriven pin shows the outside level, which the bench changes at random between checks.
   assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// ### verification/gpio_ports_e_to_h_tb.sv
/*
 * Self-checking bench for the port E to H block: APB master tasks, a bit-level model of pin
 * ownership and read-back, random pins and peripheral controls, unmapped access and mid-run reset.
 * Assumes the APB slave answers within a few cycles and pins settle within six cycles.
 */
`timescale 1ns/1ps
module gpio_ports_e_to_h_tb;
   import gpeh_pkg::*;
   logic i_clock = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ser = 0, tx = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, r;
   logic [3:0] tas = 4'h0, taoe = 4'h0, taout = 4'h0;
   logic [1:0] tbs = 2'h0, tboe = 2'h0, tbout = 2'h0;
   logic [4:0] kie = 5'h00;
   logic [19:0] ext = 20'h00000, dir = 20'h00000, lat, xoe, xout, xpin, xrd;
   wire [31:0] prdata;
   wire pready, pslverr, rx;
   wire [19:0] oe, out, pin;
   wire [3:0] tap;
   wire [1:0] tbp;
   wire [4:0] kwp;
   int fails = 0, n_tests = 0;
   int base[4] = '{0, 8, 15, 18};
   int wid[4] = '{8, 7, 3, 2};

   gpeh_ports gpeh_ports_inst (.i_clock(i_clock), .i_rst(rst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_port_e_pin(pin[7:0]), .i_port_f_pin(pin[14:8]),
      .i_port_g_pin(pin[17:15]), .i_port_h_pin(pin[19:18]), .o_port_e_out(out[7:0]),
      .o_port_f_out(out[14:8]), .o_port_g_out(out[17:15]), .o_port_h_out(out[19:18]),
      .o_port_e_oe(oe[7:0]), .o_port_f_oe(oe[14:8]), .o_port_g_oe(oe[17:15]), .o_port_h_oe(oe[19:18]),
      .i_serial_iface_enable(ser), .i_serial_tx_data(tx), .o_serial_rx_data(rx),
      .i_timer_a_edge_level_select(tas), .i_timer_a_oe(taoe), .i_timer_a_out(taout),
      .o_timer_a_channel_pin(tap), .i_timer_b_edge_level_select(tbs), .i_timer_b_oe(tboe),
      .i_timer_b_out(tbout), .o_timer_b_channel_pin(tbp), .i_keypad_irq_enable(kie),
      .o_keypad_wake_pins(kwp));

   gpeh_pad_model gpeh_pad_model_inst (.i_oe(oe), .i_out(out), .i_ext(ext), .o_pin(pin));

   initial begin
      forever #12.5 i_clock = ~i_clock;
   end

   task end_sim;
      if (fails == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", nm, e, g);
         fails++;
      end
   endtask

   // The request stays put until pready is seen high, so a slow slave is handled too.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
      @(posedge i_clock);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clock);
      pen <= 1'b1;
      // Answer lines are looked at mid-cycle, where they have settled, to avoid racing the slave's flops.
      // Only pready or the watchdog ends this wait; the request is dropped after the edge that completes it.
      @(negedge i_clock);
      while (pready !== 1'b1) @(negedge i_clock);
      r = prdata;
      chk("pslverr", {31'h0, err}, {31'h0, pslverr});
      @(posedge i_clock);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task wr(input int p, input bit isdir, input logic [31:0] d);
      apb(1'b1, (isdir ? ADDR_PORT_E_DIRECTION : ADDR_PORT_E_LATCH) + 12'(4 * p), d, 1'b0);
      for (int b = 0; b < wid[p]; b++) begin
         if (isdir) dir[base[p] + b] = d[b];
         else lat[base[p] + b] = d[b];
      end
   endtask

   // Each pin has at most one peripheral owner; otherwise the direction bit and latch drive it.
   task model;
      for (int i = 0; i < 20; i++) begin
         xoe[i] = dir[i];
         xout[i] = lat[i];
         if (ser && i < 2) begin
            xoe[i] = (i == 0);
            xout[i] = tx;
         end else if (i >= 8 && i < 12 && tas[i - 8]) begin
            xoe[i] = taoe[i - 8];
            xout[i] = taout[i - 8];
         end else if (i >= 12 && i < 14 && tbs[i - 12]) begin
            xoe[i] = tboe[i - 12];
            xout[i] = tbout[i - 12];
         end else if (i >= 15 && kie[i - 15]) begin
            xoe[i] = 1'b0;
         end
         xpin[i] = xoe[i] ? xout[i] : ext[i];
         xrd[i] = dir[i] ? lat[i] : xpin[i];
      end
   endtask

   task check_all;
      repeat (6) @(posedge i_clock);
      model;
      chk("oe", xoe, oe);
      chk("out", xout & xoe, out & xoe);
      chk("periph", {xpin[11:8], xpin[13:12], xpin[19:18], xpin[17:15], xpin[1]}, {tap, tbp, kwp, rx});
      for (int p = 0; p < 4; p++) begin
         apb(1'b0, ADDR_PORT_E_LATCH + 12'(4 * p), 32'h0, 1'b0);
         chk("data", 32'((xrd >> base[p]) & 20'((1 << wid[p]) - 1)), r);
         apb(1'b0, ADDR_PORT_E_DIRECTION + 12'(4 * p), 32'h0, 1'b0);
         chk("dir", 32'((dir >> base[p]) & 20'((1 << wid[p]) - 1)), r);
      end
   endtask

   initial begin
      void'($urandom(60));
      repeat (6) @(posedge i_clock);
      rst <= 1'b0;
      check_all;
      for (int k = 0; k < 16; k++) begin
         @(posedge i_clock);
         ext <= 20'($urandom);
         {ser, tx, tas, taoe, taout, tbs, tboe, tbout, kie} <= (k < 4) ? 25'h0 : 25'($urandom);
         // Latches go first so a pin turning to output never shows a stale value.
         for (int p = 0; p < 4; p++) wr(p, 1'b0, $urandom);
         for (int p = 0; p < 4; p++) wr(p, 1'b1, $urandom);
         check_all;
      end
      apb(1'b0, 12'h040, 32'h0, 1'b1);
      chk("unmapped", 32'h0, r);
      apb(1'b1, 12'h000, 32'hffffffff, 1'b1);
      for (int p = 0; p < 4; p++) wr(p, 1'b1, 32'hffffffff);
      check_all;
      @(posedge i_clock);
      rst <= 1'b1;
      repeat (2) @(posedge i_clock);
      rst <= 1'b0;
      dir = 20'h00000;
      check_all;
      for (int p = 0; p < 4; p++) wr(p, 1'b1, 32'hffffffff);
      check_all;
      end_sim;
   end

   initial begin
      repeat (20000) @(posedge i_clock);
      fails++;
      end_sim;
   end
endmodule
